// ===== design/lep_pkg.sv
// Shared constants, field positions and address formatting for the read port.
// Assumes a single sys_clk domain and single-rate command timing.
package lep_pkg;

    localparam int DQ_W         = 72;
    localparam int CMD_W        = 11;
    localparam int ADDR_W       = 16;
    localparam int BURST_LENGTH_FIELD_W       = 8;
    localparam int SR_COUNT     = 8;
    localparam int SR_IDX_W     = 3;
    localparam int ID_W         = 5;
    localparam int REG_ADDR_W   = 7;

    // Command bus fields
    localparam int       CMD_CODE_LSB = 0;
    localparam int       CMD_BURST    = 2;
    localparam int       CMD_SRAM_LSB = 6;
    localparam logic [1:0] CMD_READ   = 2'h0;

    // Data bus address fields
    localparam int DQ_INDIRECT = 29;
    localparam int DQ_SRI_LSB  = 26;
    localparam int DQ_ID_LSB   = 21;
    localparam int DQ_TGT_LSB  = 19;
    localparam logic [ID_W-1:0] ID_BROADCAST = 5'h1f;

    // Read targets
    localparam logic [1:0] TGT_DATA = 2'h0;
    localparam logic [1:0] TGT_MASK = 2'h1;
    localparam logic [1:0] TGT_SRAM = 2'h2;
    localparam logic [1:0] TGT_REG  = 2'h3;

    // Timing in sys_clk cycles
    localparam int SINGLE_READ_CYCLES = 6;
    localparam int BURST_BASE_CYCLES  = 4;

    // Address word as the host places it on the data bus in the command cycle
    function automatic logic [DQ_W-1:0] lep_addr_word(
        input logic [ID_W-1:0]     id,
        input logic [1:0]          tgt,
        input logic                indirect,
        input logic [SR_IDX_W-1:0] srIdx,
        input logic [ADDR_W-1:0]   addr
    );
        logic [DQ_W-1:0] w;
        w = '0;
        w[DQ_ID_LSB +: ID_W] = id;
        w[DQ_TGT_LSB +: 2]   = tgt;
        if (tgt == TGT_REG)
        begin
            w[REG_ADDR_W-1:0] = addr[REG_ADDR_W-1:0];
        end
        else
        begin
            w[DQ_INDIRECT]              = indirect;
            w[DQ_SRI_LSB +: SR_IDX_W]   = srIdx;
            w[ADDR_W-1:0]               = addr;
        end
        return w;
    endfunction

endpackage

// ===== design/lep_bus_if.sv
// Shared command and data bus between the host end and one device end.
// Merges the data, acknowledge and end-of-transfer drivers; released lines read low.
interface lep_bus_if;

    logic                          cmdValid;
    logic [lep_pkg::CMD_W-1:0]     cmd;
    logic [lep_pkg::DQ_W-1:0]      hostDq;
    logic                          hostDqOe;
    logic [lep_pkg::DQ_W-1:0]      devDq;
    logic                          devDqOe;
    logic                          devAck;
    logic                          devAckOe;
    logic                          devEot;
    logic                          devEotOe;
    wire  [lep_pkg::DQ_W-1:0]      dqBus;
    wire                           ackBus;
    wire                           eotBus;

    assign dqBus  = devDqOe ? devDq : (hostDqOe ? hostDq : '0);
    assign ackBus = devAckOe & devAck;
    assign eotBus = devEotOe & devEot;

    modport host_mp (
        output cmdValid,
        output cmd,
        output hostDq,
        output hostDqOe,
        input  dqBus,
        input  ackBus,
        input  eotBus
    );

    modport dev_mp (
        input  cmdValid,
        input  cmd,
        input  dqBus,
        output devDq,
        output devDqOe,
        output devAck,
        output devAckOe,
        output devEot,
        output devEotOe
    );

endinterface

// ===== design/lep_result_regs.sv
// Bank of search result registers used for indirect read addressing.
// Written from the user side; one combinational read port.
module lep_result_regs (
    input  wire logic                                  sys_clk,
    input  wire logic                                  reset,
    input  wire logic                                  wrEn,
    input  wire logic [lep_pkg::SR_IDX_W-1:0]          wrIdx,
    input  wire logic [lep_pkg::ADDR_W-1:0]            wrData,
    input  wire logic [lep_pkg::SR_IDX_W-1:0]          rdIdx,
    output wire logic [lep_pkg::ADDR_W-1:0]            rdData
);

    typedef struct packed {
        logic [lep_pkg::SR_COUNT-1:0][lep_pkg::ADDR_W-1:0] entry;
    } lep_sr_regs_type;

    lep_sr_regs_type state_ff;
    lep_sr_regs_type nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        if (wrEn)
        begin
            nxt_state.entry[wrIdx] = wrData;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign rdData = state_ff.entry[rdIdx];

endmodule

// ===== design/lep_device_end.sv
// Device end of the lookup engine read port: decodes read commands,
// fetches locations through a user-side read port and returns them on the bus.
// Assumes the user side answers readReq with readValid one cycle later for
// arrays and registers; external SRAM may answer later.
//
// The implementer's own choices: the strobed register port and the address map.
module lep_device_end (
    input  wire logic                                  sys_clk,
    input  wire logic                                  reset,
    lep_bus_if.dev_mp                                  bus,
    input  wire logic [lep_pkg::ID_W-1:0]              deviceId,
    input  wire logic                                  last_device_flag,
    input  wire logic                                  cfgWrite,
    input  wire logic [lep_pkg::ADDR_W-1:0]            cfgStartAddr,
    input  wire logic [lep_pkg::BURST_LENGTH_FIELD_W-1:0]            burst_length_field,
    input  wire logic                                  resultWrite,
    input  wire logic [lep_pkg::SR_IDX_W-1:0]          search_result_index,
    input  wire logic [lep_pkg::ADDR_W-1:0]            resultValue,
    input  wire logic [lep_pkg::DQ_W-1:0]              readData,
    input  wire logic                                  readValid,
    output logic                                       readReq,
    output logic      [1:0]                            readTarget,
    output logic      [lep_pkg::ADDR_W-1:0]            readAddr,
    output logic      [2:0]                            sram_upper_address
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [2:0] {
        DEV_IDLE = 3'h0,
        DEV_C2   = 3'h1,
        DEV_C3   = 3'h3,
        DEV_LOW  = 3'h2,
        DEV_DATA = 3'h6,
        DEV_END  = 3'h7
    } lep_dev_state_type;

    typedef struct packed {
        lep_dev_state_type                 st;
        logic                              burst;
        logic [lep_pkg::ADDR_W-1:0]        read_burst_address;
        logic [lep_pkg::BURST_LENGTH_FIELD_W-1:0]        burstLen;
        logic [lep_pkg::BURST_LENGTH_FIELD_W-1:0]        remain;
        logic                              rdReq;
        logic [1:0]                        rdTgt;
        logic [lep_pkg::ADDR_W-1:0]        rdAddr;
        logic [2:0]                        sramUp;
        logic [lep_pkg::DQ_W-1:0]          dq;
        logic                              dqOe;
        logic                              ack;
        logic                              ackOe;
        logic                              end_of_transfer;
        logic                              eotOe;
    } lep_dev_regs_type;

    lep_dev_regs_type state_ff;
    lep_dev_regs_type nxt_state;

    localparam logic [lep_pkg::BURST_LENGTH_FIELD_W-1:0] BURST_LENGTH_FIELD_ONE = 8'h01;
    localparam logic [lep_pkg::ADDR_W-1:0] ADDR_ONE = 16'h0001;

    logic [lep_pkg::ADDR_W-1:0] resultAddr;
    logic [lep_pkg::DQ_W-1:0]   dqIn;
    logic [1:0]                 cmdTgt;
    logic                       cmdBurst;
    logic                       selected;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic lep_is_selected(
        input logic [lep_pkg::DQ_W-1:0] dq,
        input logic [lep_pkg::ID_W-1:0] id,
        input logic                     lastDev
    );
        logic [lep_pkg::ID_W-1:0] f;
        f = dq[lep_pkg::DQ_ID_LSB +: lep_pkg::ID_W];
        if (f == lep_pkg::ID_BROADCAST)
        begin
            return lastDev;
        end
        return f == id;
    endfunction

    function automatic logic [lep_pkg::ADDR_W-1:0] lep_single_addr(
        input logic [lep_pkg::DQ_W-1:0]   dq,
        input logic [lep_pkg::ADDR_W-1:0] sr
    );
        if (dq[lep_pkg::DQ_TGT_LSB +: 2] == lep_pkg::TGT_REG)
        begin
            // Bits between the register address and the target are reserved
            return {{(lep_pkg::ADDR_W-lep_pkg::REG_ADDR_W){1'b0}},
                    dq[lep_pkg::REG_ADDR_W-1:0]};
        end
        if (dq[lep_pkg::DQ_INDIRECT])
        begin
            return {sr[lep_pkg::ADDR_W-1:2], sr[1:0] | dq[1:0]};
        end
        return dq[lep_pkg::ADDR_W-1:0];
    endfunction

    assign dqIn     = bus.dqBus;
    assign cmdTgt   = dqIn[lep_pkg::DQ_TGT_LSB +: 2];
    // A burst aimed at registers or SRAM degrades to a single read
    assign cmdBurst = bus.cmd[lep_pkg::CMD_BURST] && !cmdTgt[1];
    assign selected = lep_is_selected(dqIn, deviceId, last_device_flag);

    lep_result_regs u_result_regs (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wrEn    (resultWrite),
        .wrIdx   (search_result_index),
        .wrData  (resultValue),
        .rdIdx   (dqIn[lep_pkg::DQ_SRI_LSB +: lep_pkg::SR_IDX_W]),
        .rdData  (resultAddr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        nxt_state       = state_ff;
        nxt_state.rdReq = 1'b0;
        if (cfgWrite)
        begin
            nxt_state.read_burst_address = cfgStartAddr;
            nxt_state.burstLen           = burst_length_field;
        end
        unique case (state_ff.st)
            DEV_IDLE:
            begin
                // Unselected devices stay here with every driver off
                if (bus.cmdValid && selected &&
                    bus.cmd[lep_pkg::CMD_CODE_LSB +: 2] == lep_pkg::CMD_READ)
                begin
                    nxt_state.st     = DEV_C2;
                    nxt_state.burst  = cmdBurst;
                    nxt_state.rdTgt  = cmdTgt;
                    nxt_state.sramUp = bus.cmd[lep_pkg::CMD_SRAM_LSB +: 3];
                    if (cmdBurst)
                    begin
                        // Zero length is taken as one access
                        nxt_state.rdAddr = state_ff.read_burst_address;
                        nxt_state.remain = (state_ff.burstLen == '0) ?
                                           BURST_LENGTH_FIELD_ONE : state_ff.burstLen;
                    end
                    else
                    begin
                        nxt_state.rdAddr = lep_single_addr(dqIn, resultAddr);
                        nxt_state.remain = BURST_LENGTH_FIELD_ONE;
                    end
                end
            end
            DEV_C2:
            begin
                nxt_state.st    = DEV_C3;
                nxt_state.rdReq = 1'b1;
            end
            DEV_C3:
            begin
                nxt_state.st    = DEV_LOW;
                nxt_state.dqOe  = 1'b1;
                nxt_state.ackOe = 1'b1;
                nxt_state.ack   = 1'b0;
                nxt_state.eotOe = state_ff.burst;
                nxt_state.end_of_transfer   = 1'b0;
            end
            DEV_LOW:
            begin
                // SRAM answers late, so acknowledge stays low until data is in
                if (readValid)
                begin
                    nxt_state.st     = DEV_DATA;
                    nxt_state.dq     = readData;
                    nxt_state.ack    = 1'b1;
                    nxt_state.remain = state_ff.remain - BURST_LENGTH_FIELD_ONE;
                    if (state_ff.burst)
                    begin
                        nxt_state.end_of_transfer                = (state_ff.remain == BURST_LENGTH_FIELD_ONE);
                        nxt_state.read_burst_address = state_ff.read_burst_address +
                                                       ADDR_ONE;
                        // Fetch ahead so the data is in by the next low cycle
                        if (state_ff.remain != BURST_LENGTH_FIELD_ONE)
                        begin
                            nxt_state.rdReq  = 1'b1;
                            nxt_state.rdAddr = state_ff.read_burst_address + ADDR_ONE;
                        end
                    end
                end
            end
            DEV_DATA:
            begin
                nxt_state.ack = 1'b0;
                nxt_state.end_of_transfer = 1'b0;
                if (state_ff.remain != '0)
                begin
                    nxt_state.st = DEV_LOW;
                end
                else
                begin
                    nxt_state.st   = DEV_END;
                    nxt_state.dqOe = 1'b0;
                end
            end
            DEV_END:
            begin
                nxt_state.st    = DEV_IDLE;
                nxt_state.ackOe = 1'b0;
                nxt_state.eotOe = 1'b0;
                nxt_state.burst = 1'b0;
            end
            default:
            begin
                nxt_state.st = DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign bus.devDq          = state_ff.dq;
    assign bus.devDqOe        = state_ff.dqOe;
    assign bus.devAck         = state_ff.ack;
    assign bus.devAckOe       = state_ff.ackOe;
    assign bus.devEot         = state_ff.end_of_transfer;
    assign bus.devEotOe       = state_ff.eotOe;
    assign readReq            = state_ff.rdReq;
    assign readTarget         = state_ff.rdTgt;
    assign readAddr           = state_ff.rdAddr;
    assign sram_upper_address = state_ff.sramUp;

endmodule

// ===== design/lep_host_end.sv
// Host end of the lookup engine read port: turns one user request into a
// read command and hands back each returned word.
// Assumes the device end shares sys_clk and single-rate command timing.
module lep_host_end (
    input  wire logic                                  sys_clk,
    input  wire logic                                  reset,
    lep_bus_if.host_mp                                 bus,
    input  wire logic                                  reqValid,
    input  wire logic                                  reqBurst,
    input  wire logic [1:0]                            reqTarget,
    input  wire logic [lep_pkg::ID_W-1:0]              reqDeviceId,
    input  wire logic                                  reqIndirect,
    input  wire logic [lep_pkg::SR_IDX_W-1:0]          reqResultIndex,
    input  wire logic [lep_pkg::ADDR_W-1:0]            reqAddr,
    input  wire logic [2:0]                            reqSramUpper,
    output logic                                       reqReady,
    output logic                                       rspValid,
    output logic      [lep_pkg::DQ_W-1:0]              rspData,
    output logic                                       rspLast
);

    typedef enum logic [1:0] {
        HOST_IDLE = 2'h0,
        HOST_CMD  = 2'h1,
        HOST_WAIT = 2'h3,
        HOST_TAIL = 2'h2
    } lep_host_state_type;

    typedef struct packed {
        lep_host_state_type            st;
        logic                          burst;
        logic                          cmdValid;
        logic [lep_pkg::CMD_W-1:0]     cmd;
        logic [lep_pkg::DQ_W-1:0]      dq;
        logic                          dqOe;
        logic                          ready;
        logic                          rspValid;
        logic [lep_pkg::DQ_W-1:0]      rspData;
        logic                          rspLast;
    } lep_host_regs_type;

    lep_host_regs_type state_ff;
    lep_host_regs_type nxt_state;
    logic              burstOk;

    // Registers and SRAM are never read as a burst
    assign burstOk = reqBurst && !reqTarget[1];

    always_comb
    begin
        nxt_state          = state_ff;
        nxt_state.rspValid = 1'b0;
        unique case (state_ff.st)
            HOST_IDLE:
            begin
                nxt_state.ready = 1'b1;
                if (reqValid)
                begin
                    nxt_state.st       = HOST_CMD;
                    nxt_state.ready    = 1'b0;
                    nxt_state.burst    = burstOk;
                    nxt_state.cmdValid = 1'b1;
                    nxt_state.cmd      = '0;
                    nxt_state.cmd[lep_pkg::CMD_CODE_LSB +: 2] = lep_pkg::CMD_READ;
                    nxt_state.cmd[lep_pkg::CMD_BURST]         = burstOk;
                    if (reqTarget == lep_pkg::TGT_SRAM)
                    begin
                        nxt_state.cmd[lep_pkg::CMD_SRAM_LSB +: 3] = reqSramUpper;
                    end
                    nxt_state.dq   = lep_pkg::lep_addr_word(reqDeviceId, reqTarget,
                                         reqIndirect, reqResultIndex, reqAddr);
                    nxt_state.dqOe = 1'b1;
                end
            end
            HOST_CMD:
            begin
                nxt_state.st       = HOST_WAIT;
                nxt_state.cmdValid = 1'b0;
                nxt_state.cmd      = '0;
                nxt_state.dqOe     = 1'b0;
            end
            HOST_WAIT:
            begin
                if (bus.ackBus == 1'b1)
                begin
                    nxt_state.rspValid = 1'b1;
                    nxt_state.rspData  = bus.dqBus;
                    nxt_state.rspLast  = !state_ff.burst || (bus.eotBus == 1'b1);
                    if (!state_ff.burst || bus.eotBus == 1'b1)
                    begin
                        nxt_state.st = HOST_TAIL;
                    end
                end
            end
            HOST_TAIL:
            begin
                // The device still drives acknowledge low in this cycle
                nxt_state.st    = HOST_IDLE;
                nxt_state.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign bus.cmdValid = state_ff.cmdValid;
    assign bus.cmd      = state_ff.cmd;
    assign bus.hostDq   = state_ff.dq;
    assign bus.hostDqOe = state_ff.dqOe;
    assign reqReady     = state_ff.ready;
    assign rspValid     = state_ff.rspValid;
    assign rspData      = state_ff.rspData;
    assign rspLast      = state_ff.rspLast;

endmodule

// ===== verif/lep_read_checker.sv
// Bus timing checker for the read port between host end and device end.
// Assumes one sys_clk domain and a device user side that answers in cycle 4.
module lep_read_checker (
    input wire logic                      sys_clk,
    input wire logic                      reset,
    input wire logic                      cmdValid,
    input wire logic [lep_pkg::CMD_W-1:0] cmd,
    input wire logic                      hostDqOe,
    input wire logic                      devDqOe,
    input wire logic                      devAck,
    input wire logic                      devAckOe,
    input wire logic                      devEot,
    input wire logic                      devEotOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_single_cmd;
        cmdValid && !cmd[2] && cmd[1:0] == lep_pkg::CMD_READ ##3 devAckOe;
    endsequence
    sequence s_single_rsp;
        !devAck && devDqOe ##1 devAck ##1 !devAck && !devDqOe ##1 !devAckOe;
    endsequence
    sequence s_burst_end;
        devEotOe && !devEot && !devAck && !devDqOe ##1 !devAckOe && !devEotOe;
    endsequence
    property p_single_read;
        s_single_cmd |-> s_single_rsp;
    endproperty
    property p_cmd_pulse;
        cmdValid |=> !cmdValid;
    endproperty
    property p_host_float;
        cmdValid |=> !hostDqOe [*2];
    endproperty
    property p_burst_start;
        cmdValid && cmd[2] ##3 devAckOe |-> devEotOe && !devEot && !devAck && devDqOe;
    endproperty
    property p_ack_pulse;
        devAckOe && devAck |=> devAckOe && !devAck;
    endproperty
    property p_eot_last;
        devEotOe && devEot |-> devAck ##1 s_burst_end;
    endproperty
    property p_ack_start;
        $rose(devAckOe) |-> !devAck && devDqOe;
    endproperty
    property p_no_clash;
        !(devDqOe && hostDqOe);
    endproperty
    property p_quiet;
        devDqOe |-> devAckOe;
    endproperty
    a_single_read: assert property (p_single_read)
        else $error("single read timing wrong");
    a_cmd_pulse: assert property (p_cmd_pulse)
        else $error("command valid longer than one cycle");
    a_host_float: assert property (p_host_float)
        else $error("host drives data bus after command");
    a_burst_start: assert property (p_burst_start)
        else $error("burst start wrong");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge high too long");
    a_eot_last: assert property (p_eot_last)
        else $error("burst end wrong");
    a_ack_start: assert property (p_ack_start)
        else $error("acknowledge does not start low");
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive data bus");
    a_quiet: assert property (p_quiet)
        else $error("data driven outside response");
endmodule

// ===== verif/tb_top.sv
// Random and corner reads from host end to device end over one bus.
// Assumes the device user side may answer each readReq one cycle later.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, reset, reqValid, reqBurst, reqIndirect, cfgWrite, resultWrite;
    logic        readValid, lastFlag, reqReady, rspValid, rspLast, readReq;
    logic [1:0]  reqTarget, readTarget;
    logic [4:0]  reqDeviceId, devId;
    logic [2:0]  reqResultIndex, reqSramUpper, srIdx, sramUpper;
    logic [15:0] reqAddr, cfgStart, srVal, readAddr, burstAddr;
    logic [15:0] srMem [8];
    logic [7:0]  cfgLen;
    logic [71:0] rspData, readData;
    int          err_count, check_count, ackCnt, cyc, seed, r;
    lep_bus_if bus ();
    lep_host_end u_lep_host_end (.sys_clk(sys_clk), .reset(reset), .bus(bus),
        .reqValid(reqValid), .reqBurst(reqBurst), .reqTarget(reqTarget),
        .reqDeviceId(reqDeviceId), .reqIndirect(reqIndirect), .reqResultIndex(reqResultIndex),
        .reqAddr(reqAddr), .reqSramUpper(reqSramUpper), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast));
    lep_device_end u_lep_device_end (.sys_clk(sys_clk), .reset(reset), .bus(bus),
        .deviceId(devId), .last_device_flag(lastFlag), .cfgWrite(cfgWrite),
        .cfgStartAddr(cfgStart), .burst_length_field(cfgLen), .resultWrite(resultWrite),
        .search_result_index(srIdx), .resultValue(srVal), .readData(readData),
        .readValid(readValid), .readReq(readReq), .readTarget(readTarget),
        .readAddr(readAddr), .sram_upper_address(sramUpper));
    lep_read_checker u_lep_read_checker (.sys_clk(sys_clk), .reset(reset),
        .cmdValid(bus.cmdValid), .cmd(bus.cmd), .hostDqOe(bus.hostDqOe),
        .devDqOe(bus.devDqOe), .devAck(bus.devAck), .devAckOe(bus.devAckOe),
        .devEot(bus.devEot), .devEotOe(bus.devEotOe));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [71:0] exp_word(logic [1:0] t, logic [15:0] a, logic [2:0] u);
        return {t, 3'h0, (t == lep_pkg::TGT_SRAM) ? u : 3'h0, {4{a}}};
    endfunction
    function automatic logic [15:0] exp_addr(logic [1:0] t, logic d, logic [2:0] i,
                                             logic [15:0] a);
        if (t == lep_pkg::TGT_REG) return {9'h000, a[6:0]};
        if (d) return {srMem[i][15:2], srMem[i][1:0] | a[1:0]};
        return a;
    endfunction
    task automatic chk(input string name, input logic [71:0] e, input logic [71:0] g);
        check_count++;
        if (e !== g) begin err_count++; $display("unexpected %s: expected %h seen %h", name, e, g); end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Zero length is kept as a corner: the device must treat it as one access
    task automatic init(input logic [7:0] len, input logic lf);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge sys_clk);
            srMem[k] = 16'($random(seed));
            resultWrite <= 1'b1; srIdx <= 3'(k); srVal <= srMem[k];
        end
        @(posedge sys_clk);
        burstAddr = 16'($random(seed));
        resultWrite <= 1'b0; cfgWrite <= 1'b1; cfgStart <= burstAddr;
        cfgLen <= len; lastFlag <= lf;
        @(posedge sys_clk);
        cfgWrite <= 1'b0;
    endtask
    // Values are sampled in the edge's active region, so they are the settled pre-edge ones
    task automatic do_read(input logic b, input logic [1:0] t, input logic [4:0] id,
                           input logic d, input logic [2:0] i, input logic [15:0] a);
        int n, w;
        logic sel;
        logic [2:0] u;
        u = 3'($random(seed));
        sel = (id == devId) || (id == lep_pkg::ID_BROADCAST && lastFlag);
        n = (b && cfgLen != 0) ? int'(cfgLen) : 1;
        for (w = 0; reqReady !== 1'b1 && w < 20; w++) @(posedge sys_clk);
        ackCnt = 0;
        reqValid <= 1'b1; reqBurst <= b; reqTarget <= t; reqDeviceId <= id;
        reqIndirect <= d; reqResultIndex <= i; reqAddr <= a; reqSramUpper <= u;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        if (!sel)
        begin
            repeat (12) @(posedge sys_clk);
            chk("ackCnt", 0, ackCnt);
            do_reset();
            init(cfgLen, lastFlag);
            return;
        end
        for (int k = 0; k < n; k++)
        begin
            for (w = 0; w < 40; w++) begin @(posedge sys_clk); if (rspValid === 1'b1) break; end
            chk("rspValid", 1'b1, rspValid);
            chk("rspData", exp_word(t, b ? 16'(burstAddr + k) : exp_addr(t, d, i, a), u), rspData);
            chk("rspLast", k == n - 1, rspLast);
        end
        for (w = 0; reqReady !== 1'b1 && w < 20; w++) @(posedge sys_clk);
        chk("ackCnt", 2 * n + 1, ackCnt);
        if (b) burstAddr = 16'(burstAddr + n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        readValid <= readReq;
        readData <= exp_word(readTarget, readAddr, sramUpper);
        if (bus.devAckOe === 1'b1) ackCnt++;
        cyc++;
        if (cyc > 20000) begin err_count++; final_report(); end
    end
    initial
    begin
        seed = 32'h0000_e806;
        {reqValid, reqBurst, reqIndirect, cfgWrite, resultWrite, readValid, lastFlag} = '0;
        {reqTarget, reqDeviceId, reqResultIndex, reqSramUpper, reqAddr} = '0;
        {cfgStart, srVal, cfgLen, srIdx, readData} = '0;
        devId = 5'h0a;
        reset = 1'b1;
        do_reset();
        init(8'h00, 1'b1);
        do_read(1'b1, lep_pkg::TGT_DATA, devId, 1'b0, 3'h0, 16'hffff);
        do_read(1'b0, lep_pkg::TGT_REG, 5'h1f, 1'b0, 3'h0, 16'hffff);
        do_read(1'b0, lep_pkg::TGT_MASK, devId, 1'b1, 3'h7, 16'h0003);
        init(8'h03, 1'b0);
        do_read(1'b1, lep_pkg::TGT_MASK, devId, 1'b0, 3'h0, 16'h0000);
        do_read(1'b1, lep_pkg::TGT_DATA, devId, 1'b0, 3'h0, 16'h1234);
        do_read(1'b0, lep_pkg::TGT_SRAM, 5'h1f, 1'b0, 3'h0, 16'h0001);
        $display("test corner done");
        for (int j = 0; j < 80; j++)
        begin
            if (j % 20 == 0) init(8'($random(seed) & 5), 1'($random(seed)));
            r = $random(seed);
            do_read(r[2] & ~r[1], r[1:0], r[4:3] == 0 ? 5'h03 : r[4] ? devId : 5'h1f,
                    r[5], r[8:6], r[24:9]);
        end
        $display("test random done");
        final_report();
    end
endmodule
